// >>> core/scf_params.svh
// register map, field positions and crossing constants for the flag logic
`ifndef SCF_PARAMS_SVH
`define SCF_PARAMS_SVH
`define SCF_OFS_CTRL 4'h0
`define SCF_OFS_DATA 4'h4
`define SCF_OFS_ADDR 4'h8
`define SCF_OFS_MASK 4'hc
`define SCF_BIT_STARTREQ 5
`define SCF_BIT_STOPREQ 4
`define SCF_BIT_ACK 1
`define SCF_BIT_SI 0
`define SCF_BIT_HWACK 0
`define SCF_RST_FLAGS 8'h00
`define SCF_RST_ADDR 7'h00
`define SCF_RST_MASK 7'h7f
`define SCF_EV_IN 10
`define SCF_EV_N 12
`define SCF_RESP_OKAY 2'b00
`define SCF_RESP_SLVERR 2'b10
`endif

// >>> core/scf_pkg.sv
// types shared by the flag logic: event indices and the flag word
package scf_pkg;
    typedef enum logic [3:0] {
        EV_GEN_START = 4'b0000,
        EV_GEN_STOP = 4'b0001,
        EV_DET_START = 4'b0010,
        EV_DET_RSTART = 4'b0011,
        EV_DET_STOP = 4'b0100,
        EV_FRAME = 4'b0101,
        EV_ADDR_RX = 4'b0110,
        EV_BYTE_RX = 4'b0111,
        EV_TX_ACK = 4'b1000,
        EV_ACK_CYC = 4'b1001,
        EV_ARB_SCL = 4'b1010,
        EV_ARB_SDA = 4'b1011
    } scf_ev_t;

    // bit order equals the control register layout, bit 7 first
    typedef struct packed {
        logic master;
        logic transmit_mode_flag;
        logic startReq;
        logic stopReq;
        logic ackReq;
        logic arbitration_lost_flag;
        logic ack;
        logic si;
    } scf_flags_t;
endpackage : scf_pkg

// >>> core/scf_flag_logic.sv
// control and status flag update logic of a two-wire serial interface
`timescale 1ns/1ps
`include "scf_params.svh"

module scf_flag_logic (
    // system clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // axi4-lite register slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // link side, on the link clock except the raw sclIn and sdaIn pins
    input wire logic linkClk,
    input wire logic [`SCF_EV_IN-1:0] linkEvent,
    input wire logic [7:0] linkRxByte,
    input wire logic linkAckIn,
    input wire logic linkStopRsTry,
    input wire logic linkDrivingOne,
    input wire logic linkAckBit,
    input wire logic sclIn,
    input wire logic sdaIn,
    // status toward shifter and software
    output scf_pkg::scf_flags_t flags,
    output logic [7:0] txData,
    output logic autoAck,
    output logic addrMatch
);

    // link domain reset and pin synchronisers
    logic [2:0] lrSync;
    logic linkRstNQ;
    logic [2:0] sclSync;
    logic [2:0] sdaSync;
    logic sclQ;
    logic sdaQ;
    logic arbSclPrevQ;
    logic arbSdaPrevQ;
    logic [`SCF_EV_N-1:0] evLink;
    logic [`SCF_EV_N-1:0] togQ;
    logic [7:0] rxByteL;
    logic ackInL;

    // core domain
    logic [`SCF_EV_N-1:0] s1Q;
    logic [`SCF_EV_N-1:0] s2Q;
    logic [`SCF_EV_N-1:0] s3Q;
    logic [`SCF_EV_N-1:0] accQ;
    logic [`SCF_EV_N-1:0] ev;
    scf_pkg::scf_flags_t flagsQ;
    scf_pkg::scf_flags_t flagsD;
    logic [7:0] rxDataQ;
    logic [7:0] txDataQ;
    logic dataWrQ;
    logic slaveSelQ;
    logic hwAckQ;
    logic [6:0] ownAddrQ;
    logic [6:0] maskQ;
    logic awHeldQ;
    logic wHeldQ;
    logic [3:0] awAddrQ;
    logic [31:0] wDataQ;
    logic wStrb0Q;
    logic bvalidQ;
    logic [1:0] brespQ;
    logic rvalidQ;
    logic [31:0] rdataQ;
    logic [1:0] rrespQ;
    logic doWrite;
    logic ctrlWr;
    logic dataWr;
    logic siClr;
    logic arbSet;
    logic stopArb;
    logic match;

    // masked compare of a received address against the own address
    function automatic logic scf_match(input logic [6:0] rx, input logic [6:0] own,
                                       input logic [6:0] mask);
        scf_match = (((rx ^ own) & mask) == 7'h00);
    endfunction : scf_match

    // reset release into the link domain, counted once two stages agree
    always_ff @(posedge linkClk)
    begin
        lrSync <= {lrSync[1:0], reset_n};
        if (lrSync[1] == lrSync[2])
            linkRstNQ <= lrSync[2];
    end

    // bus lines come from pins, so three stages and an agreement filter
    always_ff @(posedge linkClk)
    begin
        sclSync <= {sclSync[1:0], sclIn};
        sdaSync <= {sdaSync[1:0], sdaIn};
        if (!linkRstNQ)
        begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
        end
        else
        begin
            if (sclSync[1] == sclSync[2])
                sclQ <= sclSync[2];
            if (sdaSync[1] == sdaSync[2])
                sdaQ <= sdaSync[2];
        end
    end

    // arbitration conditions become one pulse per episode
    always_comb
    begin
        evLink = {2'b00, linkEvent};
        evLink[scf_pkg::EV_ARB_SCL] = linkStopRsTry && !sclQ && !arbSclPrevQ;
        evLink[scf_pkg::EV_ARB_SDA] = linkDrivingOne && !linkAckBit && !sdaQ
                                      && !arbSdaPrevQ;
    end

    always_ff @(posedge linkClk)
    begin
        if (!linkRstNQ)
        begin
            arbSclPrevQ <= 1'b0;
            arbSdaPrevQ <= 1'b0;
        end
        else
        begin
            arbSclPrevQ <= linkStopRsTry && !sclQ;
            arbSdaPrevQ <= linkDrivingOne && !linkAckBit && !sdaQ;
        end
    end

    // received byte and ack bit stay put until the next such event,
    // which is a bit time away, so the core reads them after the toggle
    always_ff @(posedge linkClk)
    begin
        if (!linkRstNQ)
        begin
            rxByteL <= 8'h00;
            ackInL <= 1'b1;
        end
        else
        begin
            if (linkEvent[scf_pkg::EV_ADDR_RX] || linkEvent[scf_pkg::EV_BYTE_RX])
                rxByteL <= linkRxByte;
            if (linkEvent[scf_pkg::EV_ACK_CYC])
                ackInL <= linkAckIn;
        end
    end

    // one toggle per event kind carries it across; the link clock may stop
    // between frames, a held toggle just waits
    genvar gi;
    generate
        for (gi = 0; gi < `SCF_EV_N; gi++)
        begin : g_ev
            always_ff @(posedge linkClk)
            begin
                if (!linkRstNQ)
                    togQ[gi] <= 1'b0;
                else if (evLink[gi])
                    togQ[gi] <= ~togQ[gi];
            end

            always_ff @(posedge core_clk)
            begin
                s1Q[gi] <= togQ[gi];
                s2Q[gi] <= s1Q[gi];
                s3Q[gi] <= s2Q[gi];
                if (!reset_n)
                    accQ[gi] <= 1'b0;
                else if (s2Q[gi] == s3Q[gi])
                    accQ[gi] <= s3Q[gi];
            end

            assign ev[gi] = reset_n && (s2Q[gi] == s3Q[gi]) && (s3Q[gi] != accQ[gi]);
        end
    endgenerate

    // axi write: address and data taken in either order, answer one edge later
    assign s_axi_awready = !awHeldQ && !bvalidQ;
    assign s_axi_wready = !wHeldQ && !bvalidQ;
    assign doWrite = awHeldQ && wHeldQ && !bvalidQ;
    // upper byte lanes carry no fields, so a write without lane 0 changes nothing
    assign ctrlWr = doWrite && wStrb0Q && (awAddrQ == `SCF_OFS_CTRL);
    assign dataWr = doWrite && wStrb0Q && (awAddrQ == `SCF_OFS_DATA);

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            awAddrQ <= 4'h0;
            wDataQ <= 32'h0000_0000;
            wStrb0Q <= 1'b0;
            bvalidQ <= 1'b0;
            brespQ <= `SCF_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeldQ <= 1'b1;
                awAddrQ <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeldQ <= 1'b1;
                wDataQ <= {s_axi_wdata[31:8], s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};
                wStrb0Q <= s_axi_wstrb[0];
            end
            if (doWrite)
            begin
                awHeldQ <= 1'b0;
                wHeldQ <= 1'b0;
                bvalidQ <= 1'b1;
                brespQ <= `SCF_RESP_OKAY;
            end
            else if (bvalidQ && s_axi_bready)
                bvalidQ <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalidQ;
    assign s_axi_bresp = brespQ;

    // configuration registers; only byte lane 0 carries fields
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            hwAckQ <= 1'b0;
            ownAddrQ <= `SCF_RST_ADDR;
            maskQ <= `SCF_RST_MASK;
            txDataQ <= 8'h00;
        end
        else if (doWrite && wStrb0Q)
        begin
            if (awAddrQ == `SCF_OFS_ADDR)
            begin
                ownAddrQ <= wDataQ[7:1];
                hwAckQ <= wDataQ[`SCF_BIT_HWACK];
            end
            if (awAddrQ == `SCF_OFS_MASK)
                maskQ <= wDataQ[7:1];
            if (awAddrQ == `SCF_OFS_DATA)
                txDataQ <= wDataQ[7:0];
        end
    end

    // axi read: one cycle to the answer, address bits 1:0 are dropped so every offset hits a register and none answers slverr
    assign s_axi_arready = !rvalidQ;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            rvalidQ <= 1'b0;
            rdataQ <= 32'h0000_0000;
            rrespQ <= `SCF_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalidQ <= 1'b1;
            rrespQ <= `SCF_RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'b00})
                `SCF_OFS_CTRL: rdataQ <= {24'h000000, flagsQ};
                `SCF_OFS_DATA: rdataQ <= {24'h000000, rxDataQ};
                `SCF_OFS_ADDR: rdataQ <= {24'h000000, ownAddrQ, hwAckQ};
                `SCF_OFS_MASK: rdataQ <= {24'h000000, maskQ, 1'b0};
                default:
                begin
                    rdataQ <= 32'h0000_0000;
                    rrespQ <= `SCF_RESP_SLVERR;
                end
            endcase
        end
        else if (rvalidQ && s_axi_rready)
            rvalidQ <= 1'b0;
    end

    assign s_axi_rvalid = rvalidQ;
    assign s_axi_rdata = rdataQ;
    assign s_axi_rresp = rrespQ;

    assign match = scf_match(rxByteL[7:1], ownAddrQ, maskQ);

    // flag next state; each flag's hardware set is applied last so an
    // event in the same cycle as a software clear is never lost
    always_comb
    begin
        flagsD = flagsQ;
        siClr = ctrlWr && !wDataQ[`SCF_BIT_SI] && flagsQ.si;
        stopArb = ev[scf_pkg::EV_DET_STOP] && flagsQ.master && !ev[scf_pkg::EV_GEN_STOP];
        arbSet = ev[scf_pkg::EV_ARB_SCL] || ev[scf_pkg::EV_ARB_SDA] || stopArb
                 || (ev[scf_pkg::EV_DET_RSTART] && flagsQ.master && !flagsQ.startReq);
        if (ctrlWr)
        begin
            flagsD.startReq = wDataQ[`SCF_BIT_STARTREQ];
            flagsD.stopReq = wDataQ[`SCF_BIT_STOPREQ];
            flagsD.ack = wDataQ[`SCF_BIT_ACK];
            flagsD.si = wDataQ[`SCF_BIT_SI];
        end
        if (ev[scf_pkg::EV_GEN_STOP] || arbSet)
            flagsD.master = 1'b0;
        if (ev[scf_pkg::EV_GEN_START])
            flagsD.master = 1'b1;
        if (ev[scf_pkg::EV_DET_START] || arbSet || (ev[scf_pkg::EV_FRAME] && !dataWrQ))
            flagsD.transmit_mode_flag = 1'b0;
        if (ev[scf_pkg::EV_GEN_START] || (ev[scf_pkg::EV_FRAME] && dataWrQ))
            flagsD.transmit_mode_flag = 1'b1;
        if (ev[scf_pkg::EV_ADDR_RX])
            flagsD.startReq = 1'b1;
        if (ev[scf_pkg::EV_GEN_STOP])
            flagsD.stopReq = 1'b0;
        if ((ev[scf_pkg::EV_DET_STOP] && slaveSelQ) || stopArb)
            flagsD.stopReq = 1'b1;
        if (ev[scf_pkg::EV_ACK_CYC])
            flagsD.ackReq = 1'b0;
        if (!hwAckQ && (ev[scf_pkg::EV_BYTE_RX] || ev[scf_pkg::EV_ADDR_RX]))
            flagsD.ackReq = 1'b1;
        if (siClr)
            flagsD.arbitration_lost_flag = 1'b0;
        if (arbSet)
            flagsD.arbitration_lost_flag = 1'b1;
        if (ev[scf_pkg::EV_ACK_CYC])
            flagsD.ack = !ackInL;
        if (hwAckQ && ev[scf_pkg::EV_BYTE_RX])
            flagsD.ack = 1'b1;
        if (hwAckQ && ev[scf_pkg::EV_ADDR_RX])
            flagsD.ack = match;
        if (ev[scf_pkg::EV_GEN_START] || arbSet
            || ev[scf_pkg::EV_BYTE_RX] || ev[scf_pkg::EV_TX_ACK]
            || (ev[scf_pkg::EV_ADDR_RX] && (match || !hwAckQ))
            || ev[scf_pkg::EV_DET_STOP])
            flagsD.si = 1'b1;
    end

    // flags and tracking state, all on the system clock
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            flagsQ <= `SCF_RST_FLAGS;
            rxDataQ <= 8'h00;
            dataWrQ <= 1'b0;
            slaveSelQ <= 1'b0;
        end
        else
        begin
            flagsQ <= flagsD;
            if (ev[scf_pkg::EV_ADDR_RX] || ev[scf_pkg::EV_BYTE_RX])
                rxDataQ <= rxByteL;
            if (dataWr)
                dataWrQ <= 1'b1;
            else if (ev[scf_pkg::EV_FRAME])
                dataWrQ <= 1'b0;
            if (ev[scf_pkg::EV_ADDR_RX])
                slaveSelQ <= match || !hwAckQ;
            else if (ev[scf_pkg::EV_DET_STOP])
                slaveSelQ <= 1'b0;
        end
    end

    assign flags = flagsQ;
    assign txData = txDataQ;
    assign autoAck = hwAckQ;
    assign addrMatch = match;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence sRestartUnreq;
        ev[scf_pkg::EV_DET_RSTART] && flagsQ.master && !flagsQ.startReq;
    endsequence
    sequence sArbThenClear;
        flagsQ.arbitration_lost_flag ##1 (siClr && !arbSet);
    endsequence

    a_master_set: assert property (ev[scf_pkg::EV_GEN_START] |=> flagsQ.master)
        else $error("master flag not set after own start");
    a_master_drop: assert property ((arbSet && !ev[scf_pkg::EV_GEN_START]) |=>
        !flagsQ.master && flagsQ.arbitration_lost_flag && flagsQ.si)
        else $error("arbitration loss did not drop master");
    a_tx_frame: assert property ((ev[scf_pkg::EV_FRAME] && !ev[scf_pkg::EV_GEN_START]) |=>
        flagsQ.transmit_mode_flag == $past(dataWrQ))
        else $error("transmit mode not taken from data write at frame start");
    a_tx_detclr: assert property ((ev[scf_pkg::EV_DET_START] && !ev[scf_pkg::EV_GEN_START]
        && !ev[scf_pkg::EV_FRAME]) |=> !flagsQ.transmit_mode_flag)
        else $error("transmit mode survived detected start");
    a_startreq_hold: assert property ((flagsQ.startReq && !ctrlWr) |=> flagsQ.startReq)
        else $error("hardware cleared start request");
    a_stop_gen: assert property ((ev[scf_pkg::EV_GEN_STOP] && !ctrlWr && !ev[scf_pkg::EV_DET_STOP])
        |=> !flagsQ.stopReq)
        else $error("stop request not cleared after stop generated");
    a_ackreq_cyc: assert property ((ev[scf_pkg::EV_ACK_CYC] && !ev[scf_pkg::EV_BYTE_RX]
        && !ev[scf_pkg::EV_ADDR_RX]) |=> !flagsQ.ackReq)
        else $error("ack request not cleared by ack cycle");
    a_arb_restart: assert property (sRestartUnreq |=> flagsQ.arbitration_lost_flag ##1 flagsQ.si [*1])
        else $error("unrequested repeated start not flagged");
    a_arb_clear: assert property (sArbThenClear |=> !flagsQ.arbitration_lost_flag)
        else $error("arbitration lost not cleared with interrupt flag");
    a_ack_follow: assert property ((ev[scf_pkg::EV_ACK_CYC] && !ctrlWr && !hwAckQ) |=>
        flagsQ.ack == !ackInL)
        else $error("ack flag does not follow incoming ack bit");
    a_si_sticky: assert property ((flagsQ.si && !ctrlWr) |=> flagsQ.si)
        else $error("hardware cleared serial interrupt flag");
    a_si_byte: assert property ((ev[scf_pkg::EV_BYTE_RX] || ev[scf_pkg::EV_TX_ACK]) |=>
        flagsQ.si)
        else $error("byte event did not raise serial interrupt");
    a_si_stop: assert property (ev[scf_pkg::EV_DET_STOP] |=> flagsQ.si)
        else $error("stop did not raise serial interrupt");
    a_bresp_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped before taken");
endmodule : scf_flag_logic

// >>> test/scf_link_model.sv
// behavioural model of the far side: link clock, event pulses and bus lines
`timescale 1ns/1ps
`include "scf_params.svh"

module scf_link_model (
    // link clock and event pulses
    output logic linkClk,
    output logic [`SCF_EV_IN-1:0] linkEvent,
    output logic [7:0] linkRxByte,
    output logic linkAckIn,
    // shifter levels and raw bus lines
    output logic linkStopRsTry,
    output logic linkDrivingOne,
    output logic linkAckBit,
    output logic sclIn,
    output logic sdaIn
);
    // idle bus: pulled-up lines high, link clock parked low
    initial
    begin
        linkClk = 1'b0;
        linkEvent = '0;
        linkRxByte = 8'h00;
        linkAckIn = 1'b1;
        {linkStopRsTry, linkDrivingOne, linkAckBit} = 3'b000;
        {sclIn, sdaIn} = 2'b11;
    end

    // clock only runs while a frame is in flight
    task run(input int n);
        repeat (2 * n) #16 linkClk = ~linkClk;
    endtask : run

    // one pulse across exactly one rising edge, spaced well apart
    task pulse(input int ev, input logic [7:0] b, input logic a);
        run(4);
        linkRxByte = b;
        linkAckIn = a;
        linkEvent[ev] = 1'b1;
        run(1);
        linkEvent = '0;
        run(4);
    endtask : pulse

    // another master holds scl or sda low against our attempt
    task clash(input logic onScl, input logic inAck);
        linkAckBit = inAck;
        linkStopRsTry = onScl;
        sclIn = !onScl;
        linkDrivingOne = !onScl;
        sdaIn = onScl;
        run(8);
        {linkStopRsTry, linkDrivingOne, linkAckBit} = 3'b000;
        {sclIn, sdaIn} = 2'b11;
        run(4);
    endtask : clash
endmodule : scf_link_model

// >>> test/scf_flag_logic_bench.sv
// self-checking bench for the flag logic, link events and register access
`timescale 1ns/1ps
`include "scf_params.svh"

module scf_flag_logic_bench;
    logic core_clk, reset_n, linkClk, linkAckIn, linkStopRsTry, linkDrivingOne;
    logic linkAckBit, sclIn, sdaIn, autoAck, addrMatch;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [`SCF_EV_IN-1:0] linkEvent;
    logic [7:0] linkRxByte, txData;
    logic [2:0] hs;
    scf_pkg::scf_flags_t flags;
    int fails = 0;
    int nTests = 0;

    assign hs = {rvalid, arready, bvalid};

    scf_flag_logic scf_flag_logic_i (
        .core_clk(core_clk), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .linkClk(linkClk), .linkEvent(linkEvent), .linkRxByte(linkRxByte),
        .linkAckIn(linkAckIn), .linkStopRsTry(linkStopRsTry),
        .linkDrivingOne(linkDrivingOne), .linkAckBit(linkAckBit), .sclIn(sclIn),
        .sdaIn(sdaIn), .flags(flags), .txData(txData), .autoAck(autoAck),
        .addrMatch(addrMatch)
    );

    scf_link_model scf_link_model_i (
        .linkClk(linkClk), .linkEvent(linkEvent), .linkRxByte(linkRxByte),
        .linkAckIn(linkAckIn), .linkStopRsTry(linkStopRsTry),
        .linkDrivingOne(linkDrivingOne), .linkAckBit(linkAckBit), .sclIn(sclIn), .sdaIn(sdaIn)
    );

    // verdict and end of run, also reached by a stuck handshake
    task test_done;
        $display("comparisons %0d, mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // flag bits under a mask
    task fl(input logic [7:0] m, input logic [7:0] e);
        chk({24'h0, flags & m}, {24'h0, e});
    endtask : fl

    // handshake seen high at a falling edge is taken at the next rising edge
    task waitHi(input int s);
        int k;
        k = 0;
        do
        begin
            @(negedge core_clk);
            k++;
        end
        while (hs[s] !== 1'b1 && k < 40);
        if (hs[s] !== 1'b1)
        begin
            fails++;
            test_done();
        end
    endtask : waitHi

    // address and data offered together, each dropped once taken
    task axw(input logic [3:0] a, input logic [7:0] d);
        logic aw, w, ta, tw;
        int k;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= 3'b111;
        {aw, w} = 2'b11;
        k = 0;
        while ((aw || w) && k < 40)
        begin
            @(negedge core_clk);
            ta = aw && awready === 1'b1;
            tw = w && wready === 1'b1;
            @(posedge core_clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            aw = aw && !ta;
            w = w && !tw;
            k++;
        end
        // a channel never taken is a stuck handshake
        if (aw || w)
        begin
            fails++;
            test_done();
        end
        waitHi(0);
        chk({30'h0, bresp}, {30'h0, `SCF_RESP_OKAY});
        @(posedge core_clk);
        bready <= 1'b0;
    endtask : axw

    task axr(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        waitHi(1);
        @(posedge core_clk);
        arvalid <= 1'b0;
        waitHi(2);
        d = rdata;
        chk({30'h0, rresp}, {30'h0, `SCF_RESP_OKAY});
        @(posedge core_clk);
        rready <= 1'b0;
    endtask : axr

    // link event, then time for the crossing and the flag update
    task ev(input int e, input logic [7:0] b = 8'h00, input logic a = 1'b0);
        scf_link_model_i.pulse(e, b, a);
        repeat (6) @(negedge core_clk);
    endtask : ev

    task clash(input logic onScl, input logic inAck);
        scf_link_model_i.clash(onScl, inAck);
        repeat (6) @(negedge core_clk);
    endtask : clash

    // software clear of startReq, stopReq, ack and si
    task clr;
        axw(`SCF_OFS_CTRL, 8'h00);
    endtask : clr

    task tReset;
        logic [31:0] d;
        fl(8'hff, 8'h00);
        axr(`SCF_OFS_MASK, d);
        chk(d & 32'hfe, 32'hfe);
        axr(`SCF_OFS_ADDR, d);
        chk(d, 32'h0);
    endtask : tReset

    task tOwn;
        logic [31:0] d;
        ev(0);
        fl(8'hc1, 8'hc1);
        clr();
        axr(`SCF_OFS_CTRL, d);
        chk(d, 32'hc0);
        ev(1);
        fl(8'h80, 8'h00);
    endtask : tOwn

    task tArb;
        ev(0);
        clr();
        clash(1'b0, 1'b0);
        fl(8'hc5, 8'h05);
        clr();
        fl(8'h05, 8'h00);
        ev(0);
        clr();
        clash(1'b1, 1'b0);
        fl(8'h85, 8'h05);
        clr();
        ev(0);
        clr();
        ev(3);
        fl(8'h84, 8'h04);
        clr();
        ev(0);
        clr();
        clash(1'b0, 1'b1);
        fl(8'h84, 8'h80);
        ev(1);
        clr();
        // foreign stop while master: arbitration lost and stop request raised
        ev(0);
        clr();
        ev(4);
        fl(8'h95, 8'h15);
        clr();
    endtask : tArb

    task tRx;
        ev(7, 8'h3c);
        fl(8'h09, 8'h09);
        ev(9, 8'h3c, 1'b0);
        fl(8'h0a, 8'h02);
        ev(9, 8'h3c, 1'b1);
        fl(8'h02, 8'h00);
        clr();
        ev(8);
        fl(8'h01, 8'h01);
        clr();
    endtask : tRx

    task tTx;
        // start from transmit mode low so the data-written set is visible
        ev(5);
        fl(8'h40, 8'h00);
        axw(`SCF_OFS_DATA, 8'h5a);
        chk({24'h0, txData}, 32'h5a);
        ev(5);
        fl(8'h40, 8'h40);
        ev(5);
        fl(8'h40, 8'h00);
        axw(`SCF_OFS_DATA, 8'ha5);
        ev(5);
        ev(2);
        fl(8'h40, 8'h00);
    endtask : tTx

    task tSlave;
        ev(6, 8'h6a);
        fl(8'h21, 8'h21);
        clr();
        axw(`SCF_OFS_CTRL, 8'h20);
        ev(4);
        fl(8'h31, 8'h31);
        ev(1);
        fl(8'h30, 8'h20);
        clr();
        fl(8'h21, 8'h00);
        ev(9);
    endtask : tSlave

    task tHw;
        axw(`SCF_OFS_ADDR, 8'h6b);
        axw(`SCF_OFS_MASK, 8'he0);
        chk({31'h0, autoAck}, 32'h1);
        ev(6, 8'h74);
        chk({31'h0, addrMatch}, 32'h1);
        fl(8'h09, 8'h01);
        clr();
        ev(6, 8'h8a);
        chk({31'h0, addrMatch}, 32'h0);
        ev(7, 8'h11);
        fl(8'h0a, 8'h02);
    endtask : tHw

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // reset long enough for the link-side synchroniser to see it
    initial
    begin
        reset_n = 1'b0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
        fork
            scf_link_model_i.run(6);
            repeat (10) @(posedge core_clk);
        join
        reset_n <= 1'b1;
        @(negedge core_clk);
        tReset();
        tOwn();
        tArb();
        tRx();
        tTx();
        tSlave();
        tHw();
        test_done();
    end
endmodule : scf_flag_logic_bench
